// file: stx_cfg.svh
// Offsets, field positions, reset values and timing figures of the
// serial transmitter. Included by the package and by the design module.
`ifndef STX_CFG_SVH
`define STX_CFG_SVH

// Register addresses on the plain register port
`define STX_ADDR_W        5
`define STX_ADDR_TMR      5'h19
`define STX_ADDR_TSR      5'h1c
`define STX_ADDR_CTL      5'h1d
`define STX_ADDR_STAT     5'h1e

// Mode control field positions
`define STX_ENC_HI        15
`define STX_ENC_LO        13
`define STX_CRCT_HI       12
`define STX_CRCT_LO       11
`define STX_CRC_PRESET    10
`define STX_CRC_ACC       9
`define STX_CRC_END       8
`define STX_PAR_HI        7
`define STX_PAR_LO        6
`define STX_PAR_EN        5
`define STX_LEN_HI        4
`define STX_LEN_LO        2
`define STX_POL_HI        1
`define STX_POL_LO        0

// Reset values
`define STX_TMR_RST       16'h0000
`define STX_TSR_RST       16'h0000
`define STX_MODE_RST      2'h0

// CRC generator polynomials
`define STX_POLY_CCITT    32'h00001021
`define STX_POLY_CRC16    32'h00008005
`define STX_POLY_CRC32    32'h04c11db7

// Half-bit cells per serial bit
`define STX_HALVES        2

`endif

// file: stx_pkg.sv
// Types shared by the serial transmitter and its surroundings.
// Assumes stx_cfg.svh is on the include path.
`default_nettype none
`include "stx_cfg.svh"

package stx_pkg;

    typedef enum logic [2:0] {
        STX_ST_IDLE, STX_ST_START, STX_ST_SYNC, STX_ST_DATA,
        STX_ST_PAR, STX_ST_STOP, STX_ST_CRC
    } stx_state_e;

    typedef enum logic [1:0] {
        STX_MODE_ASYNC, STX_MODE_MONO, STX_MODE_SLAVED, STX_MODE_BISYNC
    } stx_mode_e;

    typedef enum logic [1:0] {
        STX_POL_OFF, STX_POL_ENDOFF, STX_POL_ON, STX_POL_CTS
    } stx_policy_e;

    typedef struct packed {
        logic                     wr;
        logic                     rd;
        logic [`STX_ADDR_W-1:0]   addr;
        logic [15:0]              wdata;
    } stx_bus_req_s;

    typedef struct packed {
        logic [7:0]  data;
        logic        last;
    } stx_char_s;

    typedef struct packed {
        logic [15:0]          tmr;
        logic [15:0]          tx_sync_pattern;
        stx_mode_e            mode;
        stx_state_e           st;
        stx_char_s [1:0]      fifo;
        logic [1:0]           cnt;
        logic                 rdy;
        logic [7:0]           shreg;
        logic                 last;
        logic [5:0]           bitn;
        logic                 half;
        logic                 syn2;
        logic                 par;
        logic [31:0]          crc;
        logic                 lvl;
        logic                 txd;
        logic [15:0]          rdata;
        logic                 busy;
    } stx_regs_s;

endpackage
`default_nettype wire

// file: stx_tx.sv
// Serial transmitter with mode control, line encoding, parity, CRC and
// sync character insertion, plus a two-entry character buffer.
// Assumes a register master on the plain port and a character source
// with valid/ready; all inputs are synchronous to clk_i.
//
// Notes on behaviour
// - Code 000 sends NRZ, 001 inverts, 010 NRZI-Mark, 011 NRZI-Space.
// - Line code 100 sends Biphase-Mark and 101 sends Biphase-Space.
// - Line code 110 sends Manchester and 111 Differential Manchester.
// - CRC select 00 is CRC-CCITT, 01 is CRC-16, 10 is the 32-bit CRC.
// - The CRC starts at all zeros with preset bit 0, else all ones.
// - Characters enter the CRC only while the accumulate bit is set.
// - With the append bit set a sync frame ends with its CRC value.
// - Parity kind 00 even, 01 odd, 10 constant zero, 11 constant one.
// - With parity enabled each data character carries a parity bit; sync characters carry none.
// - Width 000 sends eight bits and 001 to 111 send one to seven.
// - Policy 00 stops at once; 01 finishes the frame or character.
// - Policy 10 enables always; 11 enables only while CTS is high.
// - Bisync sends the upper sync byte as the second sync character.
// - The lower sync byte is the mono sync or first bisync character.
`timescale 1ns/1ps
`default_nettype none
`include "stx_cfg.svh"

module stx_tx (
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    input  wire stx_pkg::stx_bus_req_s bus_i,
    output logic [15:0]             rdata_o,
    input  wire stx_pkg::stx_char_s in_char_i,
    input  wire logic               in_valid_i,
    output logic                    in_ready_o,
    input  wire logic               cts_i,
    output logic                    txd_o,
    output logic                    busy_o
);
    import stx_pkg::*;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] crc_step(input logic [31:0] c,
                                             input logic b,
                                             input logic [1:0] sel);
        logic fb;
        fb = 1'b0;
        if (sel == 2'h2) begin
            fb = c[31] ^ b;
            crc_step = {c[30:0], 1'b0} ^ (fb ? `STX_POLY_CRC32 : 32'h0);
        end else begin
            fb = c[15] ^ b;
            crc_step = {16'h0, c[14:0], 1'b0} ^
                       (fb ? ((sel == 2'h1) ? `STX_POLY_CRC16
                                            : `STX_POLY_CCITT) : 32'h0);
        end
    endfunction

    // Returns the line level for one half-bit cell
    function automatic logic encode(input logic [2:0] code, input logic d,
                                    input logic half, input logic lvl);
        case (code)
            3'h0: encode = d;
            3'h1: encode = ~d;
            3'h2: encode = half ? lvl : lvl ^ d;
            3'h3: encode = half ? lvl : lvl ^ ~d;
            3'h4: encode = half ? lvl ^ d : ~lvl;
            3'h5: encode = half ? lvl ^ ~d : ~lvl;
            3'h6: encode = half ? ~d : d;
            default: encode = half ? ~lvl : lvl ^ ~d;
        endcase
    endfunction

    stx_regs_s r;
    stx_regs_s n;

    logic [2:0]  f_enc;
    logic [1:0]  f_crct;
    logic [1:0]  f_par;
    logic [2:0]  f_len;
    stx_policy_e f_pol;
    logic [5:0]  char_len;
    logic [5:0]  crc_len;
    logic        sync_mode;
    logic        go;
    logic        cur_bit;
    logic        par_bit;
    logic        load;
    logic        pop;
    logic        push;
    logic        char_done;
    logic [1:0]  cnt_tmp;

    assign f_enc     = r.tmr[`STX_ENC_HI:`STX_ENC_LO];
    assign f_crct    = r.tmr[`STX_CRCT_HI:`STX_CRCT_LO];
    assign f_par     = r.tmr[`STX_PAR_HI:`STX_PAR_LO];
    assign f_len     = r.tmr[`STX_LEN_HI:`STX_LEN_LO];
    assign f_pol     = stx_policy_e'(r.tmr[`STX_POL_HI:`STX_POL_LO]);
    assign char_len  = (f_len == 3'h0) ? 6'h08 : {3'h0, f_len};
    assign crc_len   = (f_crct == 2'h2) ? 6'h20 : 6'h10;
    assign sync_mode = (r.mode != STX_MODE_ASYNC);
    assign go        = (f_pol == STX_POL_ON) ||
                       ((f_pol == STX_POL_CTS) && cts_i);

    always_comb begin
        unique case (f_par)
            2'h0: par_bit = r.par;
            2'h1: par_bit = ~r.par;
            2'h2: par_bit = 1'b0;
            default: par_bit = 1'b1;
        endcase
    end

    always_comb begin
        unique case (r.st)
            STX_ST_START: cur_bit = 1'b0;
            STX_ST_STOP:  cur_bit = 1'b1;
            STX_ST_PAR:   cur_bit = par_bit;
            STX_ST_CRC:   cur_bit = (f_crct == 2'h2) ? r.crc[31]
                                                     : r.crc[15];
            default:      cur_bit = r.shreg[0];
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        n         = r;
        load      = 1'b0;
        pop       = 1'b0;
        char_done = 1'b0;
        cnt_tmp   = r.cnt;
        push      = in_valid_i && r.rdy;
        n.rdata   = 16'h0;

        // ********************************************************
        // Register port
        // ********************************************************
        if (bus_i.wr) begin
            unique case (bus_i.addr)
                `STX_ADDR_TMR: n.tmr  = bus_i.wdata;
                `STX_ADDR_TSR: n.tx_sync_pattern  = bus_i.wdata;
                `STX_ADDR_CTL: n.mode = stx_mode_e'(bus_i.wdata[1:0]);
                default: ;
            endcase
        end
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                `STX_ADDR_TMR:  n.rdata = r.tmr;
                `STX_ADDR_TSR:  n.rdata = r.tx_sync_pattern;
                `STX_ADDR_CTL:  n.rdata = {14'h0, r.mode};
                `STX_ADDR_STAT: n.rdata = {8'h0, r.txd, r.cnt, go,
                                           1'b0, r.st};
                default:        n.rdata = 16'h0;
            endcase
        end

        // ********************************************************
        // Transmit sequencer
        // ********************************************************
        if (f_pol == STX_POL_OFF) begin
            n.st   = STX_ST_IDLE;
            n.lvl  = 1'b1;
            n.txd  = 1'b1;
            n.half = 1'b0;
        end else if (r.st == STX_ST_IDLE) begin
            n.lvl  = 1'b1;
            n.txd  = 1'b1;
            n.half = 1'b0;
            if (go && (r.cnt != 2'h0)) begin
                n.bitn = 6'h0;
                if (sync_mode) begin
                    n.st    = STX_ST_SYNC;
                    n.shreg = r.tx_sync_pattern[7:0];
                    n.syn2  = (r.mode == STX_MODE_BISYNC);
                    n.crc   = r.tmr[`STX_CRC_PRESET] ? 32'hffffffff
                                                     : 32'h0;
                end else begin
                    n.st = STX_ST_START;
                end
            end
        end else begin
            n.lvl  = encode(f_enc, cur_bit, r.half,
                            r.lvl);
            n.txd  = n.lvl;
            n.half = ~r.half;
            if (r.half) begin
                unique case (r.st)
                    STX_ST_START: load = 1'b1;
                    STX_ST_SYNC: begin
                        n.shreg = r.shreg >> 1;
                        n.bitn  = r.bitn + 6'h1;
                        if (r.bitn == 6'h7) begin
                            n.bitn = 6'h0;
                            if (r.syn2) begin
                                n.shreg = r.tx_sync_pattern[15:8];
                                n.syn2  = 1'b0;
                            end else if (r.cnt != 2'h0) begin
                                load = 1'b1;
                            end else begin
                                n.shreg = r.tx_sync_pattern[7:0];
                            end
                        end
                    end
                    STX_ST_DATA: begin
                        if (sync_mode && r.tmr[`STX_CRC_ACC]) begin
                            n.crc = crc_step(r.crc, cur_bit,
                                             f_crct);
                        end
                        n.par   = r.par ^ cur_bit;
                        n.shreg = r.shreg >> 1;
                        n.bitn  = r.bitn + 6'h1;
                        if (r.bitn == char_len - 6'h1) begin
                            if (r.tmr[`STX_PAR_EN]) begin
                                n.st = STX_ST_PAR;
                            end else begin
                                char_done = 1'b1;
                            end
                        end
                    end
                    STX_ST_PAR: char_done = 1'b1;
                    STX_ST_STOP: begin
                        n.st = (go && (r.cnt != 2'h0)) ? STX_ST_START
                                                       : STX_ST_IDLE;
                    end
                    STX_ST_CRC: begin
                        n.crc  = r.crc << 1;
                        n.bitn = r.bitn + 6'h1;
                        if (r.bitn == crc_len - 6'h1) begin
                            n.st = STX_ST_IDLE;
                        end
                    end
                    default: n.st = STX_ST_IDLE;
                endcase
            end
        end

        // Async ends each character with a stop bit; sync ends frames
        if (char_done) begin
            n.bitn = 6'h0;
            if (!sync_mode) begin
                n.st = STX_ST_STOP;
            end else if (r.last) begin
                n.st = r.tmr[`STX_CRC_END] ? STX_ST_CRC
                                           : STX_ST_IDLE;
            end else if (r.cnt != 2'h0) begin
                load = 1'b1;
            end else begin
                n.st    = STX_ST_SYNC;
                n.shreg = r.tx_sync_pattern[7:0];
            end
        end

        if (load) begin
            n.st    = STX_ST_DATA;
            n.shreg = r.fifo[0].data;
            n.last  = r.fifo[0].last;
            n.bitn  = 6'h0;
            n.par   = 1'b0;
            pop     = 1'b1;
        end

        // ********************************************************
        // Two-entry buffer: head at index 0
        // ********************************************************
        if (pop) begin
            n.fifo[0] = r.fifo[1];
            cnt_tmp   = r.cnt - 2'h1;
        end
        if (push) begin
            n.fifo[cnt_tmp[0]] = in_char_i;
            cnt_tmp            = cnt_tmp + 2'h1;
        end
        n.cnt = cnt_tmp;
        n.rdy = (cnt_tmp != 2'h2);
        // Busy is kept in a flop so that busy_o needs no output decode
        n.busy = (n.st != STX_ST_IDLE);
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r       <= '0;
            r.tmr   <= `STX_TMR_RST;
            r.tx_sync_pattern   <= `STX_TSR_RST;
            r.mode  <= stx_mode_e'(`STX_MODE_RST);
            r.st    <= STX_ST_IDLE;
            r.rdy   <= 1'b1;
            r.lvl   <= 1'b1;
            r.txd   <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ************************************************************
    // Outputs, each straight from a flop
    // ************************************************************
    assign rdata_o    = r.rdata;
    assign in_ready_o = r.rdy;
    assign txd_o      = r.txd;
    assign busy_o     = r.busy;

endmodule // stx_tx
`default_nettype wire

// file: stx_tx_chk.sv
// Port checker for the serial transmitter.
// Bound to every stx_tx instance; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module stx_tx_chk (
    input wire logic                  clk_i,
    input wire logic                  rst_n_i,
    input wire stx_pkg::stx_bus_req_s bus_i,
    input wire logic [15:0]           rdata_o,
    input wire stx_pkg::stx_char_s    in_char_i,
    input wire logic                  in_valid_i,
    input wire logic                  in_ready_o,
    input wire logic                  cts_i,
    input wire logic                  txd_o,
    input wire logic                  busy_o
);
    import stx_pkg::*;
    logic [15:0] tmr_r;
    logic [15:0] tsr_r;
    // ********
    // Shadow of the mode control and sync pattern registers
    // ********
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tmr_r <= 16'h0000;
            tsr_r <= 16'h0000;
        end else if (bus_i.wr) begin
            if (bus_i.addr == 5'h19)
                tmr_r <= bus_i.wdata;
            if (bus_i.addr == 5'h1c)
                tsr_r <= bus_i.wdata;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_read_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 16'h0000)
        else $error("read data not zero outside a read");
    a_mode_read: assert property (
        $past(bus_i.rd && bus_i.addr == 5'h19) |-> rdata_o == tmr_r)
        else $error("mode control read back wrong");
    a_sync_read: assert property (
        $past(bus_i.rd && bus_i.addr == 5'h1c) |-> rdata_o == tsr_r)
        else $error("sync pattern read back wrong");
    a_unmapped_read: assert property (
        $past(bus_i.rd && bus_i.addr == 5'h00) |-> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_stop_now: assert property (
        tmr_r[1:0] == 2'h0 && $past(tmr_r[1:0]) == 2'h0 |-> !busy_o)
        else $error("busy while transmitter stopped");
    a_start_gate: assert property (
        $rose(busy_o) |-> $past(tmr_r[1]))
        else $error("frame started while not enabled");
    a_cts_gate: assert property (
        $rose(busy_o) && $past(tmr_r[1:0]) == 2'h3
        |-> $past(cts_i) || $past(cts_i, 2))
        else $error("frame started without clear to send");
    a_ready_keep: assert property (in_ready_o && !in_valid_i |=> in_ready_o)
        else $error("ready dropped without a push");
    a_line_idle: assert property (!busy_o [*4] |-> txd_o)
        else $error("line not high while idle");
endmodule // stx_tx_chk
bind stx_tx stx_tx_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .in_char_i(in_char_i),
    .in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .cts_i(cts_i),
    .txd_o(txd_o), .busy_o(busy_o));
`default_nettype wire

// file: stx_rx_model.sv
// Remote receiver: decodes asynchronous NRZ characters from the line
// and drives clear-to-send. Shares the transmitter's clock.
`timescale 1ns/1ps
`default_nettype none
module stx_rx_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       txd_i,
    input  wire logic       cts_en_i,
    input  wire logic [3:0] nbits_i,
    output logic            cts_o,
    output logic [9:0]      word_o,
    output logic [7:0]      cnt_o
);
    logic [4:0] pos_r;
    logic [9:0] sh_r;
    assign cts_o = cts_en_i;
    // ********
    // Start detect, one sample per bit cell
    // ********
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_r <= 5'h00;
            sh_r <= 10'h000;
            word_o <= 10'h000;
            cnt_o <= 8'h00;
        end else if (pos_r == 5'h00) begin
            if (!txd_i)
                pos_r <= 5'h01;
        end else begin
            pos_r <= pos_r + 5'h01;
            if (!pos_r[0] && pos_r <= {nbits_i, 1'b0})
                sh_r <= {txd_i, sh_r[9:1]};
            if (pos_r == {nbits_i, 1'b0} + 5'h02) begin
                word_o <= sh_r >> (4'ha - nbits_i);
                cnt_o <= cnt_o + 8'h01;
                pos_r <= 5'h00;
            end
        end
    end
endmodule // stx_rx_model
`default_nettype wire

// file: test_stx_tx.sv
// Self-checking bench for stx_tx with a remote receiver model.
// Assumes the checker is bound and the receiver model compiled.
`timescale 1ns/1ps
`default_nettype none
module test_stx_tx;
    import stx_pkg::*;
    logic         clk_i = 1'b0;
    logic         rst_n_i = 1'b0;
    stx_bus_req_s bus_i = '0;
    stx_char_s    in_char_i = '0;
    logic         in_valid_i = 1'b0;
    logic         cts_en = 1'b0;
    logic [3:0]   nbits = 4'h8;
    logic         inv = 1'b0;
    logic         busy_q = 1'b0;
    logic [15:0]  rdata_o;
    logic         in_ready_o, cts_i, txd_o, busy_o;
    logic [9:0]   word;
    logic [7:0]   wcnt;
    int           mismatches = 0;
    int           n_tests = 0;
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
    stx_tx dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
        .rdata_o(rdata_o), .in_char_i(in_char_i), .in_valid_i(in_valid_i),
        .in_ready_o(in_ready_o), .cts_i(cts_i), .txd_o(txd_o),
        .busy_o(busy_o));
    // Undo the code 001 inversion while a character is on the line
    always @(posedge clk_i) begin
        busy_q <= busy_o;
    end
    stx_rx_model far (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .txd_i(txd_o ^ (inv & busy_q)),
        .cts_en_i(cts_en), .nbits_i(nbits), .cts_o(cts_i), .word_o(word),
        .cnt_o(wcnt));
    always #4 clk_i = ~clk_i;
    // ********
    // Access tasks
    // ********
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_i);
        bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        bus_i <= '0;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk_i);
        bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk_i);
        bus_i <= '0;
        #1 `CHK(rdata_o, e)
    endtask
    task automatic send(input logic [7:0] d);
        @(posedge clk_i);
        in_char_i <= '{data: d, last: 1'b1};
        in_valid_i <= 1'b1;
        do @(posedge clk_i); while (!in_ready_o);
        in_valid_i <= 1'b0;
    endtask
    task automatic waitw(input logic [7:0] c, input logic [9:0] e);
        for (int i = 0; i < 400 && wcnt == c; i++)
            @(posedge clk_i);
        `CHK(wcnt, c + 8'h01)
        `CHK(word, e)
    endtask
    function automatic logic [9:0] expw(input logic [7:0] d,
        input logic [2:0] w, input logic pe, input logic [1:0] pk);
        logic [3:0] n;
        logic [9:0] e;
        n = (w == 3'h0) ? 4'h8 : {1'b0, w};
        e = {2'b00, d} & ((10'h001 << n) - 10'h001);
        if (pe)
            e[n] = pk[1] ? pk[0] : (^e ^ pk[0]);
        return e;
    endfunction
    task automatic run(input logic [7:0] d, input logic [2:0] w,
        input logic pe, input logic [1:0] pk, input logic [1:0] pol);
        logic [7:0] c;
        nbits <= ((w == 3'h0) ? 4'h8 : {1'b0, w}) + {3'h0, pe};
        wr(5'h19, {8'h00, pk, pe, w, pol});
        c = wcnt;
        send(d);
        if (pol == 2'h3) begin
            repeat (40) @(posedge clk_i);
            `CHK(busy_o, 1'b0)
            cts_en <= 1'b1;
        end
        waitw(c, expw(d, w, pe, pk));
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        end_sim;
    end
    // ********
    // Tests
    // ********
    initial begin
        logic [7:0] c;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdc(5'h19, 16'h0000);
        rdc(5'h1c, 16'h0000);
        wr(5'h1c, 16'hc3a5);
        rdc(5'h1c, 16'hc3a5);
        rdc(5'h00, 16'h0000);
        wr(5'h1d, 16'h0003);
        rdc(5'h1d, 16'h0003);
        wr(5'h1d, 16'h0000);
        rdc(5'h1d, 16'h0000);
        run(8'ha5, 3'h0, 1'b0, 2'h0, 2'h2);
        run(8'h6b, 3'h7, 1'b1, 2'h0, 2'h2);
        run(8'h6b, 3'h7, 1'b1, 2'h1, 2'h2);
        run(8'h13, 3'h1, 1'b1, 2'h2, 2'h2);
        run(8'h12, 3'h3, 1'b1, 2'h3, 2'h3);
        run(8'hff, 3'h5, 1'b0, 2'h1, 2'h2);
        nbits <= 4'h8;
        inv <= 1'b1;
        wr(5'h19, 16'h2002);
        c = wcnt;
        send(8'h3c);
        waitw(c, 10'h03c);
        repeat (4) @(posedge clk_i);
        inv <= 1'b0;
        wr(5'h19, 16'h0002);
        c = wcnt;
        send(8'h5a);
        repeat (10) @(posedge clk_i);
        wr(5'h19, 16'h0001);
        waitw(c, 10'h05a);
        c = wcnt;
        send(8'h81);
        send(8'h42);
        repeat (2) @(posedge clk_i);
        #1 `CHK(in_ready_o, 1'b0)
        `CHK(busy_o, 1'b0)
        rdc(5'h1e, 16'h00c0);
        wr(5'h19, 16'h0002);
        waitw(c, 10'h081);
        waitw(c + 8'h01, 10'h042);
        send(8'h00);
        repeat (8) @(posedge clk_i);
        #1 `CHK(busy_o, 1'b1)
        wr(5'h19, 16'h0000);
        repeat (2) @(posedge clk_i);
        #1 `CHK(busy_o, 1'b0)
        `CHK(txd_o, 1'b1)
        repeat (30) @(posedge clk_i);
        end_sim;
    end
endmodule // test_stx_tx
`default_nettype wire
